/* File: fap_top.sv */
// flash access protection: permission check, key locks, apb registers
`timescale 1ns/1ps
`include "fap_cfg.svh"
module fap_top import fap_pkg::*; (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// operating mode and option state
	input  wire logic        dbg_active,
	input  wire logic        rop_enabled,
	input  wire logic        privileged,
	input  wire logic [7:0]  ubc_blocks,
	input  wire logic [7:0]  protected_code_area_blocks,
	// memory access request
	input  wire logic        acc_valid,
	input  wire logic [15:0] acc_addr,
	input  wire logic [1:0]  acc_kind,
	input  wire logic [7:0]  acc_wdata,
	input  wire logic        acc_from_dbg,
	output logic             acc_grant,
	output logic             acc_deny,
	// erase request
	output logic             memory_unlock_key_erase
);

	// ------------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------------
	logic        apb_setup;
	logic        apb_wr;
	logic        hit_ctrl;
	logic        hit_pkey;
	logic        hit_dkey;
	logic        hit_status;
	logic        hit_denied;
	logic        mapped;

	assign apb_setup  = psel && !penable;
	assign apb_wr     = psel && penable && pwrite;
	assign hit_ctrl   = (paddr == `FAP_OFS_CTRL);
	assign hit_pkey   = (paddr == `FAP_OFS_PKEY);
	assign hit_dkey   = (paddr == `FAP_OFS_DKEY);
	assign hit_status = (paddr == `FAP_OFS_STATUS);
	assign hit_denied = (paddr == `FAP_OFS_DENIED);
	assign mapped     = hit_ctrl || hit_pkey || hit_dkey || hit_status || hit_denied;

	// no wait states; read data is latched in the setup cycle
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ------------------------------------------------------------------
	// key locks
	// ------------------------------------------------------------------
	logic prog_unl;
	logic prog_dead;
	logic data_unl;
	logic data_open;
	logic prog_relock;
	logic data_relock;

	// writing zero to the program or data unlock flag relocks; writing one never unlocks
	assign prog_relock = apb_wr && hit_status && !pwdata[`FAP_ST_PUL_BIT];
	assign data_relock = apb_wr && hit_status && !pwdata[`FAP_ST_DUL_BIT];

	fap_key_unlock #(
		.KEY_FIRST  (`FAP_PKEY_FIRST),
		.KEY_SECOND (`FAP_PKEY_SECOND),
		.ONCE       (1'b1)
	) u_prog_key (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.key_we     (apb_wr && hit_pkey),
		.key_data   (pwdata[7:0]),
		.relock     (prog_relock),
		.unlocked   (prog_unl),
		.dead       (prog_dead),
		.open_pulse ()
	);

	fap_key_unlock #(
		.KEY_FIRST  (`FAP_DKEY_FIRST),
		.KEY_SECOND (`FAP_DKEY_SECOND),
		.ONCE       (1'b0)
	) u_data_key (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.key_we     (apb_wr && hit_dkey),
		.key_data   (pwdata[7:0]),
		.relock     (data_relock),
		.unlocked   (data_unl),
		.dead       (),
		.open_pulse (data_open)
	);

	// ------------------------------------------------------------------
	// control register and option unlock
	// ------------------------------------------------------------------
	logic opt_sel_r;
	logic opt_unl_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			opt_sel_r <= `FAP_CTRL_RST;
		else if (apb_wr && hit_ctrl)
			opt_sel_r <= pwdata[`FAP_CTRL_OPT_BIT];
	end

	// the unlock completing wins over a relock in the same cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			opt_unl_r <= 1'b0;
		else if (data_open && opt_sel_r)
			opt_unl_r <= 1'b1;
		else if (data_relock)
			opt_unl_r <= 1'b0;
	end

	// ------------------------------------------------------------------
	// permission check
	// ------------------------------------------------------------------
	fap_area_t area;

	fap_area_decode u_decode (
		.addr         (acc_addr),
		.ubc_blocks   (ubc_blocks),
		.protected_code_area_blocks (protected_code_area_blocks),
		.area         (area)
	);

	logic ubc_defined;
	logic protected_code_area_defined;
	logic locked_out;
	logic ok;

	assign ubc_defined   = (ubc_blocks != 8'h00);
	assign protected_code_area_defined = (protected_code_area_blocks != 8'h00);
	assign locked_out    = dbg_active && rop_enabled;

	function automatic logic fap_allow(
		input fap_area_t a,
		input fap_kind_t k,
		input logic      lock_all,
		input logic      readout_protection,
		input logic      dbg,
		input logic      priv,
		input logic      via_dbg,
		input logic      ubc_def,
		input logic      protected_code_area_def,
		input logic      p_unl,
		input logic      d_unl,
		input logic      o_unl,
		input logic      rop_byte
	);
		logic rd;
		logic wr;
		logic ex;
		rd = (k == FAP_ACC_READ);
		wr = (k == FAP_ACC_WRITE);
		ex = (k == FAP_ACC_EXEC);
		fap_allow = 1'b0;
		if (lock_all) begin
			// only the readout-protection byte may be rewritten
			fap_allow = (a == FAP_AREA_OPT) && wr && rop_byte;
		end else begin
			case (a)
				FAP_AREA_VEC:   fap_allow = rd || ex || (wr && !ubc_def && p_unl);
				FAP_AREA_TRAP:  fap_allow = rd || ex || (wr && !ubc_def && p_unl && (dbg || !protected_code_area_def));
				FAP_AREA_PROTECTED_CODE_AREA: fap_allow = (rd || ex) && priv && !via_dbg;
				FAP_AREA_UBC:   fap_allow = rd || ex;
				FAP_AREA_MAIN:  fap_allow = rd || ex || (wr && p_unl);
				FAP_AREA_EEP:   fap_allow = rd || (wr && d_unl);
				FAP_AREA_OPT:   fap_allow = rd || (wr && !readout_protection && o_unl);
				FAP_AREA_OTHER: fap_allow = 1'b1;
				default:        fap_allow = 1'b0;
			endcase
		end
	endfunction

	assign ok = fap_allow(area, fap_kind_t'(acc_kind), locked_out, rop_enabled, dbg_active,
		privileged, acc_from_dbg, ubc_defined, protected_code_area_defined, prog_unl, data_unl, opt_unl_r,
		acc_addr == `FAP_ROP_ADDR);

	// a refused access simply never reaches the array
	assign acc_grant = acc_valid && ok;
	assign acc_deny  = acc_valid && !ok;

	// ------------------------------------------------------------------
	// protection removal and denial count
	// ------------------------------------------------------------------
	logic       erase_r;
	logic [7:0] denied_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			erase_r <= 1'b0;
		else
			erase_r <= acc_grant && rop_enabled && area == FAP_AREA_OPT && acc_kind == FAP_ACC_WRITE
				&& acc_addr == `FAP_ROP_ADDR && acc_wdata == `FAP_ROP_OFF_VAL;
	end

	assign memory_unlock_key_erase = erase_r;

	// saturating, so a storm of faults never wraps back to a small number
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			denied_r <= `FAP_DENIED_RST;
		else if (apb_wr && hit_denied)
			denied_r <= `FAP_DENIED_RST;
		else if (acc_deny && denied_r != 8'hff)
			denied_r <= denied_r + 8'h01;
	end

	// ------------------------------------------------------------------
	// apb read data
	// ------------------------------------------------------------------
	logic [31:0] rd_nxt;
	logic [31:0] prdata_r;

	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (hit_ctrl)
			rd_nxt[`FAP_CTRL_OPT_BIT] = opt_sel_r;
		else if (hit_status) begin
			rd_nxt[`FAP_ST_PUL_BIT]   = prog_unl;
			rd_nxt[`FAP_ST_DUL_BIT]   = data_unl;
			rd_nxt[`FAP_ST_PDEAD_BIT] = prog_dead;
			rd_nxt[`FAP_ST_OPTUL_BIT] = opt_unl_r;
		end else if (hit_denied)
			rd_nxt[7:0] = denied_r;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			prdata_r <= 32'h0000_0000;
		else if (apb_setup)
			prdata_r <= rd_nxt;
	end

	assign prdata = prdata_r;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	a_rop_dbg_block: assert property (@(posedge clk) disable iff (sys_rst)
		acc_valid && dbg_active && rop_enabled && area != FAP_AREA_OPT |-> acc_deny)
		else $error("access granted under debug readout protection");

	a_opt_rop_only: assert property (@(posedge clk) disable iff (sys_rst)
		acc_grant && dbg_active && rop_enabled |-> acc_addr == `FAP_ROP_ADDR && acc_kind == FAP_ACC_WRITE)
		else $error("option access other than protection byte");

	a_opt_user_read: assert property (@(posedge clk) disable iff (sys_rst)
		acc_valid && !dbg_active && rop_enabled && area == FAP_AREA_OPT |-> acc_grant == (acc_kind == FAP_ACC_READ))
		else $error("option bytes not read only");

	a_ubc_no_write: assert property (@(posedge clk) disable iff (sys_rst)
		acc_valid && area == FAP_AREA_UBC && acc_kind == FAP_ACC_WRITE |-> acc_deny)
		else $error("boot code area written");

	a_vector_write: assert property (@(posedge clk) disable iff (sys_rst)
		acc_grant && area == FAP_AREA_VEC && acc_kind == FAP_ACC_WRITE |-> !ubc_defined && prog_unl)
		else $error("vector written with boot area defined");

	a_trap_protected_code_area: assert property (@(posedge clk) disable iff (sys_rst)
		acc_valid && !dbg_active && protected_code_area_defined && area == FAP_AREA_TRAP && acc_kind == FAP_ACC_WRITE
		|-> acc_deny) else $error("trap vector written with protected code defined");

	a_main_locked: assert property (@(posedge clk) disable iff (sys_rst)
		acc_grant && area == FAP_AREA_MAIN && acc_kind == FAP_ACC_WRITE |-> prog_unl)
		else $error("main program written while locked");

	a_prog_relock: assert property (@(posedge clk) disable iff (sys_rst)
		prog_unl && prog_relock |=> !prog_unl && prog_dead) else $error("program flash not relocked");

	a_eep_locked: assert property (@(posedge clk) disable iff (sys_rst)
		acc_grant && area == FAP_AREA_EEP |-> acc_kind == FAP_ACC_READ || (acc_kind == FAP_ACC_WRITE && data_unl))
		else $error("data memory write while locked or executed");

	a_data_relock: assert property (@(posedge clk) disable iff (sys_rst)
		data_relock && !data_open |=> !data_unl && !opt_unl_r) else $error("data memory not relocked");

	a_opt_unlock: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(opt_unl_r) |-> $past(opt_sel_r) && $past(data_open)) else $error("option unlock without select");

	a_erase_pulse: assert property (@(posedge clk) disable iff (sys_rst)
		acc_grant && rop_enabled && acc_addr == `FAP_ROP_ADDR && acc_kind == FAP_ACC_WRITE
		&& acc_wdata == `FAP_ROP_OFF_VAL |=> memory_unlock_key_erase) else $error("no erase on protection removal");

	a_protected_code_area_access: assert property (@(posedge clk) disable iff (sys_rst)
		acc_grant && area == FAP_AREA_PROTECTED_CODE_AREA |-> privileged && acc_kind != FAP_ACC_WRITE)
		else $error("protected code reached outside privileged mode");

	a_protected_code_area_dbg: assert property (@(posedge clk) disable iff (sys_rst)
		acc_valid && acc_from_dbg && area == FAP_AREA_PROTECTED_CODE_AREA |-> acc_deny)
		else $error("protected code reached through debug port");

	a_grant_excl: assert property (@(posedge clk) disable iff (sys_rst)
		!(acc_grant && acc_deny) && (acc_valid == (acc_grant || acc_deny)))
		else $error("grant and deny inconsistent");

endmodule

/* File: fap_cfg.svh */
// constants of the flash access protection block
//
// Functional notes
// - debug port active with readout protection: core gets no access to any memory area other than the option bytes.
// - debug port active with readout protection: option writes refused except readout-protection byte.
// - normal modes with readout protection: option bytes are read only.
// - user boot code area may be read and executed, never written.
// - non-trap vectors writable in user mode only when no boot code area exists.
// - protected code area defined: trap vector not writable in user mode.
// - program flash stays write-locked until the correct program key sequence.
// - clearing the program-unlocked flag write-locks program flash again.
// - program unlock honoured once per reset; a wrong key blocks until reset.
// - data memory stays write-locked until the correct data key sequence.
// - after a wrong data or option key, a fresh sequence is accepted.
// - clearing the data-unlocked flag relocks data memory and option bytes.
// - option bytes unlock only with option select set before the data key.
// - removing readout protection erases the whole memory, option bytes included.
// - protected code area read or executed only in privileged trap mode.
// - protected code area never reached directly through the debug port.
// - main program read/write/execute, data memory read/write, writes gated by unlock.
`ifndef FAP_CFG_SVH
`define FAP_CFG_SVH

// ------------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------------
`define FAP_OFS_CTRL      12'h000
`define FAP_OFS_PKEY      12'h004
`define FAP_OFS_DKEY      12'h008
`define FAP_OFS_STATUS    12'h00c
`define FAP_OFS_DENIED    12'h010

// ------------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------------
`define FAP_CTRL_OPT_BIT  0
`define FAP_ST_PUL_BIT    0
`define FAP_ST_DUL_BIT    1
`define FAP_ST_PDEAD_BIT  2
`define FAP_ST_OPTUL_BIT  3
`define FAP_CTRL_RST      1'h0
`define FAP_DENIED_RST    8'h00

// ------------------------------------------------------------------
// unlock keys, first then second byte
// ------------------------------------------------------------------
`define FAP_PKEY_FIRST    8'h3c
`define FAP_PKEY_SECOND   8'hc3
`define FAP_DKEY_FIRST    8'hc3
`define FAP_DKEY_SECOND   8'h3c

// ------------------------------------------------------------------
// memory map of the guarded areas
// ------------------------------------------------------------------
`define FAP_EEP_LO        16'h1000
`define FAP_EEP_HI        16'h17ff
`define FAP_OPT_LO        16'h4800
`define FAP_OPT_HI        16'h48ff
`define FAP_ROP_ADDR      16'h4800
`define FAP_ROP_OFF_VAL   8'h5a
`define FAP_PROG_LO       16'h8000
`define FAP_VEC_HI        16'h807f
`define FAP_TRAP_LO       16'h8004
`define FAP_TRAP_HI       16'h8007
`define FAP_PROTECTED_CODE_AREA_LO      16'h8080
`define FAP_BLOCK_SHIFT   7

`endif

/* File: fap_pkg.sv */
// types of the flash access protection block
package fap_pkg;

	typedef enum logic [2:0] {
		FAP_AREA_VEC   = 3'h0,
		FAP_AREA_TRAP  = 3'h1,
		FAP_AREA_PROTECTED_CODE_AREA = 3'h2,
		FAP_AREA_UBC   = 3'h3,
		FAP_AREA_MAIN  = 3'h4,
		FAP_AREA_EEP   = 3'h5,
		FAP_AREA_OPT   = 3'h6,
		FAP_AREA_OTHER = 3'h7
	} fap_area_t;

	typedef enum logic [1:0] {
		FAP_ACC_READ  = 2'h0,
		FAP_ACC_WRITE = 2'h1,
		FAP_ACC_EXEC  = 2'h2
	} fap_kind_t;

	typedef enum logic [1:0] {
		FAP_KEY_IDLE = 2'h0,
		FAP_KEY_HALF = 2'h1,
		FAP_KEY_OPEN = 2'h2,
		FAP_KEY_DEAD = 2'h3
	} fap_key_st_t;

endpackage

/* File: fap_area_decode.sv */
// address to memory area decoder
`timescale 1ns/1ps
`include "fap_cfg.svh"
module fap_area_decode import fap_pkg::*; (
	// address under test
	input  wire logic [15:0] addr,
	// area sizes in blocks
	input  wire logic [7:0]  ubc_blocks,
	input  wire logic [7:0]  protected_code_area_blocks,
	// result
	output fap_area_t        area
);

	function automatic logic [16:0] fap_end(input logic [15:0] base, input logic [7:0] blocks);
		fap_end = {1'b0, base} + ({9'h000, blocks} << `FAP_BLOCK_SHIFT);
	endfunction

	logic [16:0] ubc_end;
	logic [16:0] protected_code_area_end;

	assign ubc_end   = fap_end(`FAP_PROG_LO, ubc_blocks);
	assign protected_code_area_end = fap_end(`FAP_PROTECTED_CODE_AREA_LO, protected_code_area_blocks);

	// vectors win over the code areas that overlay them
	always_comb begin
		if (addr >= `FAP_TRAP_LO && addr <= `FAP_TRAP_HI)
			area = FAP_AREA_TRAP;
		else if (addr >= `FAP_PROG_LO && addr <= `FAP_VEC_HI)
			area = FAP_AREA_VEC;
		else if (addr >= `FAP_PROTECTED_CODE_AREA_LO && {1'b0, addr} < protected_code_area_end)
			area = FAP_AREA_PROTECTED_CODE_AREA;
		else if (addr >= `FAP_PROG_LO && {1'b0, addr} < ubc_end)
			area = FAP_AREA_UBC;
		else if (addr >= `FAP_PROG_LO)
			area = FAP_AREA_MAIN;
		else if (addr >= `FAP_EEP_LO && addr <= `FAP_EEP_HI)
			area = FAP_AREA_EEP;
		else if (addr >= `FAP_OPT_LO && addr <= `FAP_OPT_HI)
			area = FAP_AREA_OPT;
		else
			area = FAP_AREA_OTHER;
	end

endmodule

/* File: fap_key_unlock.sv */
// two-byte key sequence checker with relock
`timescale 1ns/1ps
`include "fap_cfg.svh"
module fap_key_unlock import fap_pkg::*; #(
	parameter logic [7:0] KEY_FIRST  = 8'h00,
	parameter logic [7:0] KEY_SECOND = 8'h00,
	parameter bit         ONCE       = 1'b0
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// key writes and relock
	input  wire logic       key_we,
	input  wire logic [7:0] key_data,
	input  wire logic       relock,
	// state
	output logic            unlocked,
	output logic            dead,
	output logic            open_pulse
);

	fap_key_st_t st_r;
	fap_key_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			FAP_KEY_IDLE: begin
				if (key_we)
					st_nxt = (key_data == KEY_FIRST) ? FAP_KEY_HALF : (ONCE ? FAP_KEY_DEAD : FAP_KEY_IDLE);
			end
			FAP_KEY_HALF: begin
				if (key_we && key_data == KEY_SECOND)
					st_nxt = FAP_KEY_OPEN;
				else if (key_we)
					st_nxt = ONCE ? FAP_KEY_DEAD : FAP_KEY_IDLE;
			end
			FAP_KEY_OPEN: begin
				// a once-only lock cannot be reopened after a relock
				if (relock)
					st_nxt = ONCE ? FAP_KEY_DEAD : FAP_KEY_IDLE;
			end
			FAP_KEY_DEAD: st_nxt = FAP_KEY_DEAD;
			default: st_nxt = FAP_KEY_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			st_r <= FAP_KEY_IDLE;
		else
			st_r <= st_nxt;
	end

	assign unlocked   = (st_r == FAP_KEY_OPEN);
	assign dead       = (st_r == FAP_KEY_DEAD);
	assign open_pulse = (st_r == FAP_KEY_HALF) && (st_nxt == FAP_KEY_OPEN);

	a_dead_sticks: assert property (@(posedge clk) disable iff (sys_rst)
		dead |=> dead) else $error("dead key lock reopened");
	a_key_order: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(unlocked) |-> $past(st_r) == FAP_KEY_HALF && $past(key_data) == KEY_SECOND)
		else $error("unlock without key sequence");

endmodule

/* File: fap_core_model.sv */
// core and debug-tool model issuing memory access requests
`timescale 1ns/1ps
module fap_core_model (
	// request toward the guard
	output logic        acc_valid,
	output logic [15:0] acc_addr,
	output logic [1:0]  acc_kind,
	output logic [7:0]  acc_wdata,
	output logic        acc_from_dbg
);
	// ----------------------------------------
	// request drive
	// ----------------------------------------
	initial begin
		acc_valid = 1'b0;
		acc_addr = 16'h0000;
		acc_kind = 2'h0;
		acc_wdata = 8'h00;
		acc_from_dbg = 1'b0;
	end
	// called right after a rising edge; the sweep also drives writes into the boot area while it is sized
	task go(input logic [15:0] a, input logic [1:0] k, input logic [7:0] d, input logic v);
		acc_valid <= 1'b1;
		acc_addr <= a;
		acc_kind <= k;
		acc_wdata <= d;
		acc_from_dbg <= v;
	endtask
	// released address, kind and data lines show the inverse, not a stale copy
	task idle();
		acc_valid <= 1'b0;
		acc_addr <= ~acc_addr;
		acc_kind <= ~acc_kind;
		acc_wdata <= ~acc_wdata;
	endtask
endmodule

/* File: flash_access_protection_tb.sv */
// self-checking bench for the flash access protection block
`timescale 1ns/1ps
`include "fap_cfg.svh"
module flash_access_protection_tb;
	logic        clk = 1'b0, sys_rst = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        dbg_active = 1'b0, rop_enabled = 1'b0, privileged = 1'b0;
	logic [7:0]  ubc_blocks = 8'h00, protected_code_area_blocks = 8'h00;
	logic        pready, pslverr, acc_valid, acc_from_dbg, acc_grant, acc_deny, memory_unlock_key_erase, e;
	logic [31:0] prdata, q;
	logic [15:0] acc_addr;
	logic [1:0]  acc_kind;
	logic [7:0]  acc_wdata;
	int          error_cnt = 0, compares = 0, m_cnt = 0, m_ubc = 0, m_pc = 0;
	bit          m_p, m_d, m_o, m_dead, m_pst, m_dst, m_opt, m_dbg, m_rop, m_priv, m_via;
	int          at [11] = '{'h8000, 'h8004, 'h8040, 'h8080, 'h8100, 'h9000, 'h1000, 'h17ff, 'h4800, 'h4801, 'h48ff};

	fap_core_model core_inst (.acc_valid(acc_valid), .acc_addr(acc_addr), .acc_kind(acc_kind),
		.acc_wdata(acc_wdata), .acc_from_dbg(acc_from_dbg));
	fap_top fap_top_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.dbg_active(dbg_active), .rop_enabled(rop_enabled), .privileged(privileged), .ubc_blocks(ubc_blocks),
		.protected_code_area_blocks(protected_code_area_blocks), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_kind(acc_kind),
		.acc_wdata(acc_wdata), .acc_from_dbg(acc_from_dbg), .acc_grant(acc_grant), .acc_deny(acc_deny),
		.memory_unlock_key_erase(memory_unlock_key_erase));

	initial begin
		forever #25 clk = ~clk;
	end

	// ----------------------------------------
	// reference model and helpers
	// ----------------------------------------
	function automatic bit mg(int a, int k);
		bit w;
		int ar;
		w = (k == 1);
		ar = (a >= 'h8004 && a <= 'h8007) ? 1 : (a >= 'h8000 && a <= 'h807f) ? 0 :
			(a >= 'h8080 && a < 'h8080 + m_pc * 128) ? 2 : (a >= 'h8000 && a < 'h8000 + m_ubc * 128) ? 3 :
			(a >= 'h8000) ? 4 : (a >= 'h1000 && a <= 'h17ff) ? 5 : 6;
		if (m_dbg && m_rop) return ar == 6 && w && a == `FAP_ROP_ADDR;
		case (ar)
			0: return !w || (m_p && m_ubc == 0);
			1: return !w || (m_p && m_ubc == 0 && (m_dbg || m_pc == 0));
			2: return !w && m_priv && !m_via;
			3: return !w;
			4: return !w || m_p;
			5: return k == 0 || (w && m_d);
			default: return k == 0 || (w && m_o && !m_rop);
		endcase
	endfunction

	task chk(input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			error_cnt++;
			$display("[ERR] %0t mismatch seen %h expected %h", $time, s, x);
		end
	endtask

	task give_verdict();
		if (error_cnt == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rq, output logic re);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) error_cnt++;
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task reg_wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, q, e);
		chk(32'(e), 32'h0);
		case (a)
			12'h000: m_opt = d[0];
			12'h004: if (!m_dead && !m_p) begin
				if (!m_pst && d[7:0] == `FAP_PKEY_FIRST) m_pst = 1'b1;
				else if (m_pst && d[7:0] == `FAP_PKEY_SECOND) m_p = 1'b1;
				else m_dead = 1'b1;
			end
			12'h008: begin
				if (m_dst && d[7:0] == `FAP_DKEY_SECOND) begin
					m_d = 1'b1;
					m_o = m_o | m_opt;
				end
				m_dst = !m_dst && d[7:0] == `FAP_DKEY_FIRST;
			end
			12'h00c: begin
				if (!d[0] && m_p) begin
					m_p = 1'b0;
					m_dead = 1'b1;
				end
				if (!d[1]) begin
					m_d = 1'b0;
					m_o = 1'b0;
				end
			end
			default: m_cnt = 0;
		endcase
	endtask

	task chk_regs();
		apb(1'b0, 12'h00c, 32'h0, q, e);
		chk(q, {28'h0, m_o, m_dead, m_d, m_p});
		apb(1'b0, 12'h000, 32'h0, q, e);
		chk(q, {31'h0, m_opt});
		apb(1'b0, 12'h010, 32'h0, q, e);
		chk(q, 32'(m_cnt));
		apb(1'b0, 12'h004, 32'h0, q, e);
		chk(q, 32'h0);
	endtask

	task acc(input int a, input int k, input logic [7:0] wd, input bit via);
		bit g;
		@(posedge clk);
		dbg_active <= m_dbg;
		rop_enabled <= m_rop;
		privileged <= m_priv;
		ubc_blocks <= 8'(m_ubc);
		protected_code_area_blocks <= 8'(m_pc);
		core_inst.go(16'(a), 2'(k), wd, via);
		m_via = via;
		@(negedge clk);
		g = mg(a, k);
		chk(32'(acc_grant), 32'(g));
		chk(32'(acc_deny), 32'(!g));
		@(posedge clk);
		core_inst.idle();
		if (!g && m_cnt < 255) m_cnt++;
		@(negedge clk);
		chk(32'(memory_unlock_key_erase), 32'(g && k == 1 && a == `FAP_ROP_ADDR && wd == `FAP_ROP_OFF_VAL && m_rop));
	endtask

	task sweep(input int n);
		repeat (n) begin
			m_dbg = 1'($urandom % 2);
			m_rop = 1'($urandom % 2);
			m_priv = 1'($urandom % 2);
			m_ubc = ($urandom % 2) * 3;
			m_pc = $urandom % 2;
			acc(at[$urandom % 11], $urandom % 3, ($urandom % 2) ? 8'h5a : 8'($urandom), 1'($urandom % 2));
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h6b8f0375));
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		chk_regs();
		apb(1'b0, 12'h014, 32'h0, q, e);
		chk({q[30:0], e}, 32'h1);
		sweep(150);
		foreach (at[i]) begin
			m_dbg = 1'b1;
			m_rop = 1'b1;
			acc(`FAP_ROP_ADDR, 1, i[0] ? 8'h00 : `FAP_ROP_OFF_VAL, 1'b0);
		end
		reg_wr(12'h008, 32'hc3);
		reg_wr(12'h008, 32'h00);
		reg_wr(12'h008, 32'hc3);
		reg_wr(12'h008, 32'h3c);
		chk_regs();
		sweep(150);
		reg_wr(12'h00c, 32'h1);
		reg_wr(12'h000, 32'h1);
		reg_wr(12'h008, 32'hc3);
		reg_wr(12'h008, 32'h3c);
		chk_regs();
		sweep(150);
		reg_wr(12'h000, 32'h0);
		reg_wr(12'h004, 32'h3c);
		reg_wr(12'h004, 32'h00);
		reg_wr(12'h004, 32'h3c);
		reg_wr(12'h004, 32'hc3);
		chk_regs();
		sweep(100);
		m_dbg = 1'b0;
		m_rop = 1'b0;
		repeat (260) acc('h1000, 2, 8'h00, 1'b0);
		chk_regs();
		reg_wr(12'h010, 32'h0);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		{m_p, m_d, m_o, m_dead, m_pst, m_dst, m_opt} = 7'h00;
		m_cnt = 0;
		chk_regs();
		reg_wr(12'h004, 32'h3c);
		reg_wr(12'h004, 32'hc3);
		chk_regs();
		sweep(150);
		reg_wr(12'h00c, 32'h2);
		reg_wr(12'h004, 32'h3c);
		reg_wr(12'h004, 32'hc3);
		chk_regs();
		sweep(100);
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end
endmodule
